/* core/uart_rx_recovery_pkg.sv */
// Contract
// - Oversample 16x normal, 8x double speed
// - Double speed when select bit is one
// - Low line seen in idle starts detection, sample one
// - Start checked at samples 8-10 or 4-6
// - Majority high start is noise, re-wait
// - Realign bit timing on every start bit
// - Sixteen or eight sampling states per bit
// - Bit value is majority of centre samples
// - Frame ends at first stop bit
// - Stop bit zero sets frame error
// - Accept new start right after stop vote
// - Character plus parity five to ten bits
package uart_rx_recovery_pkg;

    localparam int unsigned DIV_W = 12;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned BITS_W = 4;
    localparam int unsigned FRAME_MAX = 10;
    localparam int unsigned FRAME_MIN = 5;

    localparam logic [CNT_W-1:0] SPB_NORMAL = 5'h10;
    localparam logic [CNT_W-1:0] SPB_DOUBLE = 5'h08;
    localparam logic [CNT_W-1:0] FIRST_NORMAL = 5'h08;
    localparam logic [CNT_W-1:0] FIRST_DOUBLE = 5'h04;
    localparam logic [CNT_W-1:0] SAMPLE_ONE = 5'h01;
    localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
    localparam logic [BITS_W-1:0] BITS_RESET = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b10,
        ST_STOP = 2'b11
    } rx_state_e;

    // One received character with its frame status
    typedef struct packed {
        logic [FRAME_MAX-1:0] bits;
        logic frame_error_flag;
    } rx_word_s;

    localparam int unsigned WORD_W = FRAME_MAX + 1;

    function automatic logic vote3(input logic [2:0] s);
        vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

endpackage

/* core/uart_baud_tick.sv */
module uart_baud_tick
    import uart_rx_recovery_pkg::*;
#(
    parameter int unsigned W = DIV_W
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Divisor
    input wire logic [W-1:0] baud_divisor_i,
    // Tick
    output logic tick_o
);
    if (W < 1) begin : g_bad_width
        $error("divisor width too small");
    end

    logic [W-1:0] count;

    // Tick every divisor+1 clocks
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            count <= '0;
            tick_o <= 1'b0;
        end else if (clk_en_i) begin
            if (count >= baud_divisor_i) begin
                count <= '0;
                tick_o <= 1'b1;
            end else begin
                count <= count + 1'b1;
                tick_o <= 1'b0;
            end
        end
    end
endmodule

/* core/uart_rx_skid.sv */
module uart_rx_skid
    import uart_rx_recovery_pkg::*;
#(
    parameter int unsigned W = WORD_W
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Fill side
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // Drain side
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    if (W < 1) begin : g_bad_width
        $error("buffer width too small");
    end

    // Entry 0 feeds the output directly; entry 1 holds the overflow
    logic [W-1:0] mem0;
    logic [W-1:0] mem1;
    logic [1:0] fill;

    logic push;
    logic pop;
    logic [1:0] next_fill;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        next_fill = fill + {1'b0, push} - {1'b0, pop};
    end

    // Flags registered so the handshake outputs come from flip-flops
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fill <= 2'h0;
            out_valid_o <= 1'b0;
            in_ready_o <= 1'b1;
        end else if (clk_en_i) begin
            fill <= next_fill;
            out_valid_o <= (next_fill != 2'h0);
            in_ready_o <= (next_fill != 2'h2);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mem0 <= '0;
            mem1 <= '0;
        end else if (clk_en_i) begin
            if (pop) begin
                mem0 <= (fill == 2'h2) ? mem1 : in_data_i;
            end else if (push && fill == 2'h0) begin
                mem0 <= in_data_i;
            end
            if (push && ((fill == 2'h1 && !pop) || (fill == 2'h2))) begin
                mem1 <= in_data_i;
            end
        end
    end

    always_comb begin
        out_data_o = mem0;
    end
endmodule

/* core/uart_async_rx_recovery.sv */
module uart_async_rx_recovery
    import uart_rx_recovery_pkg::*;
#(
    parameter int unsigned DIV_WIDTH = DIV_W
) (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Configuration
    input wire logic double_speed_select_i,
    input wire logic [DIV_WIDTH-1:0] baud_divisor_i,
    input wire logic [BITS_W-1:0] frame_bits_i,
    // Serial line
    input wire logic rxd_i,
    // Received characters
    output logic [FRAME_MAX-1:0] rx_data_o,
    output logic frame_error_flag_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    // Status
    output logic overrun_o,
    output logic busy_o
);
    if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin : g_bad_width
        $error("bad divisor width");
    end

    // Line synchroniser; meta is read only by line
    logic rxd_meta;
    logic rxd_line;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rxd_meta <= 1'b1;
            rxd_line <= 1'b1;
        end else if (clk_en_i) begin
            rxd_meta <= rxd_i;
            rxd_line <= rxd_meta;
        end
    end

    logic tick;
    uart_baud_tick #(.W(DIV_WIDTH)) u_tick (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .baud_divisor_i(baud_divisor_i),
        .tick_o(tick)
    );

    // Mode constants sampled per frame to avoid mid-frame mode changes
    logic dbl;
    logic [CNT_W-1:0] spb;
    logic [CNT_W-1:0] first_s;
    always_comb begin
        spb = dbl ? SPB_DOUBLE : SPB_NORMAL;
        first_s = dbl ? FIRST_DOUBLE : FIRST_NORMAL;
    end

    rx_state_e state;
    rx_state_e next_state;
    logic [CNT_W-1:0] sample;
    logic [2:0] votes;
    logic [BITS_W-1:0] bit_idx;
    logic [BITS_W-1:0] nbits;
    logic [FRAME_MAX-1:0] shift;
    logic push_valid;
    logic [WORD_W-1:0] push_word;
    logic buf_ready;

    logic last_sample;
    logic third_vote;
    logic voted;
    always_comb begin
        last_sample = (sample == spb);
        third_vote = (sample == first_s + 5'h02);
        voted = vote3({rxd_line, votes[1:0]});
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (!rxd_line) next_state = ST_START;
            ST_START: begin
                if (third_vote) begin
                    // Noise spike rejected, wait for next fall
                    next_state = voted ? ST_IDLE : ST_START;
                end else if (last_sample) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: if (last_sample && bit_idx == nbits - 4'h1) next_state = ST_STOP;
            // Return right after the stop vote: early start allowed
            ST_STOP: if (third_vote) next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else if (clk_en_i && tick) begin
            state <= next_state;
        end
    end

    // Sample counter restarts at one on every start edge
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sample <= 5'h00;
            votes <= 3'h0;
        end else if (clk_en_i && tick) begin
            if (state == ST_IDLE) begin
                // The idle tick that sees the line low is sample one
                sample <= SAMPLE_ONE + 5'h01;
            end else begin
                sample <= last_sample ? SAMPLE_ONE : sample + 5'h01;
            end
            if (sample == first_s || sample == first_s + 5'h01) begin
                votes <= {votes[1:0], rxd_line};
            end
        end
    end

    // Mode and length latched at the start edge
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dbl <= 1'b0;
            nbits <= BITS_RESET;
        end else if (clk_en_i && tick && state == ST_IDLE && !rxd_line) begin
            dbl <= double_speed_select_i;
            if (frame_bits_i < 4'(FRAME_MIN)) begin
                nbits <= 4'(FRAME_MIN);
            end else if (frame_bits_i > 4'(FRAME_MAX)) begin
                nbits <= 4'(FRAME_MAX);
            end else begin
                nbits <= frame_bits_i;
            end
        end
    end

    // Data bits, LSB first
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bit_idx <= BITS_RESET;
            shift <= '0;
        end else if (clk_en_i && tick) begin
            if (state == ST_START) begin
                bit_idx <= BITS_RESET;
                shift <= '0;
            end else if (state == ST_DATA) begin
                if (third_vote) begin
                    shift[bit_idx] <= voted;
                end
                if (last_sample) begin
                    bit_idx <= bit_idx + 4'h1;
                end
            end
        end
    end

    // Character handed to the buffer at the stop vote
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            push_valid <= 1'b0;
            push_word <= '0;
        end else if (clk_en_i) begin
            push_valid <= tick && state == ST_STOP && third_vote;
            if (tick && state == ST_STOP && third_vote) begin
                push_word <= {shift, ~voted};
            end
        end
    end

    // A word refused by a full buffer is dropped and flagged
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            overrun_o <= 1'b0;
            busy_o <= 1'b0;
        end else if (clk_en_i) begin
            overrun_o <= push_valid && !buf_ready;
            busy_o <= (state != ST_IDLE);
        end
    end

    logic [WORD_W-1:0] buf_data;
    logic buf_valid;
    rx_word_s out_word;
    uart_rx_skid #(.W(WORD_W)) u_buf (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .in_data_i(push_word),
        .in_valid_i(push_valid),
        .in_ready_o(buf_ready),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(rx_ready_i)
    );

    // Buffer output entries are flip-flops
    always_comb begin
        out_word = rx_word_s'(buf_data);
        rx_data_o = out_word.bits;
        frame_error_flag_o = out_word.frame_error_flag;
        rx_valid_o = buf_valid;
    end
endmodule

/* verification/rx_recovery_props.sv */
module rx_recovery_props
    import uart_rx_recovery_pkg::*;
#(
    parameter int unsigned DIV_WIDTH = DIV_W
) (
    // Clock and control
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic double_speed_select_i,
    input wire logic [DIV_WIDTH-1:0] baud_divisor_i,
    input wire logic [BITS_W-1:0] frame_bits_i,
    input wire logic rxd_i,
    input wire logic rx_ready_i,
    // Watched outputs
    input wire logic [FRAME_MAX-1:0] rx_data_o,
    input wire logic frame_error_flag_o,
    input wire logic rx_valid_o,
    input wire logic overrun_o,
    input wire logic busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_RESET_ZERO: assert property (disable iff (1'b0)
        !rst_n_i && clk_en_i |=> !rx_valid_o && !busy_o && !overrun_o)
        else $error("outputs not cleared by reset");
    AST_FREEZE: assert property (
        !clk_en_i |=> $stable(busy_o) && $stable(rx_valid_o) && $stable(rx_data_o))
        else $error("state moved while disabled");
    AST_IDLE_QUIET: assert property (
        (rxd_i && !busy_o && clk_en_i && baud_divisor_i == 0) [*5] |=> !busy_o)
        else $error("busy without a falling line");
    AST_FRAME_16X: assert property (
        $rose(busy_o) && baud_divisor_i == 0 && !double_speed_select_i |-> ##[1:215] !busy_o)
        else $error("normal frame too long");
    AST_FRAME_8X: assert property (
        $rose(busy_o) && baud_divisor_i == 0 && double_speed_select_i |-> ##[1:110] !busy_o)
        else $error("double speed frame too long");
    AST_HOLD_WORD: assert property (
        rx_valid_o && !rx_ready_i && clk_en_i
        |=> rx_valid_o && $stable(rx_data_o) && $stable(frame_error_flag_o))
        else $error("word changed before pop");
    AST_UPPER_ZERO: assert property (
        rx_valid_o && frame_bits_i == 4'h5 |-> rx_data_o[9:5] == 5'h00)
        else $error("unused bits not zero");
    AST_OVR_PULSE: assert property (
        overrun_o |=> !overrun_o)
        else $error("overrun longer than one cycle");
    cover property (rx_valid_o && frame_error_flag_o);
    cover property (overrun_o);
    cover property ($rose(busy_o) && double_speed_select_i);
endmodule
bind uart_async_rx_recovery rx_recovery_props #(.DIV_WIDTH(DIV_WIDTH)) props (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .double_speed_select_i(double_speed_select_i), .baud_divisor_i(baud_divisor_i),
    .frame_bits_i(frame_bits_i), .rxd_i(rxd_i), .rx_ready_i(rx_ready_i),
    .rx_data_o(rx_data_o), .frame_error_flag_o(frame_error_flag_o),
    .rx_valid_o(rx_valid_o), .overrun_o(overrun_o), .busy_o(busy_o));

/* verification/uart_far_tx.sv */
module uart_far_tx (
    // Clock
    input wire logic sys_clk_i,
    // Line, idle high
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_o = 1'b1;
    // Caller picks an exact bit length, well inside tolerance
    task automatic send(input logic [9:0] b, input int n, input logic stop,
            input int cpb, input int stop_len, input bit glitch);
        int i;
        int k;
        logic v;
        for (i = -1; i <= n; i++) begin
            for (k = 0; k < ((i == n) ? stop_len : cpb); k++) begin
                @(posedge sys_clk_i);
                v = (i < 0) ? 1'b0 : (i == n) ? stop : b[i];
                // One bad sample per bit must be outvoted
                line_o <= (glitch && k == cpb / 2) ? ~v : v;
            end
        end
        @(posedge sys_clk_i);
        line_o <= 1'b1;
    endtask
    task automatic spike(input int len);
        @(posedge sys_clk_i);
        line_o <= 1'b0;
        repeat (len) @(posedge sys_clk_i);
        line_o <= 1'b1;
    endtask
endmodule

/* verification/tb.sv */
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h seen %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import uart_rx_recovery_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic clk_en = 1'b1;
    logic dss = 1'b0;
    logic [DIV_W-1:0] divisor = 12'h000;
    logic [BITS_W-1:0] nbits = 4'h8;
    logic rx_ready = 1'b0;
    logic rxd;
    logic [FRAME_MAX-1:0] rx_data;
    logic fe, rx_valid, overrun, busy;
    logic ovr_seen = 1'b0;
    int errors = 0;
    int compares = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (overrun === 1'b1) ovr_seen <= 1'b1;
    uart_async_rx_recovery dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
        .double_speed_select_i(dss), .baud_divisor_i(divisor), .frame_bits_i(nbits),
        .rxd_i(rxd), .rx_data_o(rx_data), .frame_error_flag_o(fe), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready), .overrun_o(overrun), .busy_o(busy));
    uart_far_tx far (.sys_clk_i(sys_clk_i), .line_o(rxd));
    function automatic logic [9:0] msk(input logic [9:0] b, input int n);
        return b & ((10'h001 << n) - 10'h001);
    endfunction
    function automatic int cpb();
        return (dss ? 8 : 16) * (int'(divisor) + 1);
    endfunction
    task automatic cfg(input logic ds, input logic [11:0] dv, input logic [3:0] n);
        @(posedge sys_clk_i);
        dss <= ds;
        divisor <= dv;
        nbits <= n;
        @(posedge sys_clk_i);
    endtask
    task automatic expect_word(input logic [9:0] d, input logic e);
        int t;
        @(negedge sys_clk_i);
        for (t = 0; t < 4000 && rx_valid !== 1'b1; t++) @(negedge sys_clk_i);
        `CHK("rx_valid", 1'b1, rx_valid)
        `CHK("rx_data", d, rx_data)
        `CHK("frame_error", e, fe)
        @(posedge sys_clk_i);
        rx_ready <= 1'b1;
        @(posedge sys_clk_i);
        rx_ready <= 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic t_lengths;
        int ds;
        int n;
        for (ds = 0; ds < 2; ds++) for (n = 5; n <= 10; n++) begin
            cfg(ds[0], 12'h000, n[3:0]);
            far.send(10'h2b5 + n[9:0], n, 1'b1, cpb(), cpb(), n[0]);
            expect_word(msk(10'h2b5 + n[9:0], n), 1'b0);
        end
    endtask
    task automatic t_errors;
        cfg(1'b0, 12'h000, 4'h7);
        far.send(10'h05a, 7, 1'b0, cpb(), cpb(), 1'b0);
        expect_word(10'h05a, 1'b1);
        // Idle line lets the false start after a low stop be rejected first
        repeat (40) @(posedge sys_clk_i);
        far.send(10'h033, 7, 1'b1, cpb(), cpb(), 1'b1);
        expect_word(10'h033, 1'b0);
    endtask
    task automatic t_noise;
        int ds;
        for (ds = 0; ds < 2; ds++) begin
            cfg(ds[0], 12'h000, 4'h8);
            far.spike(ds ? 2 : 4);
            repeat (400) @(negedge sys_clk_i);
            `CHK("noise_valid", 1'b0, rx_valid)
            `CHK("noise_busy", 1'b0, busy)
            far.send(10'h0c3, 8, 1'b1, cpb(), cpb(), 1'b0);
            expect_word(10'h0c3, 1'b0);
            // Low up to the first check sample only: one low vote, rejected
            far.spike(ds ? 4 : 8);
            repeat (400) @(negedge sys_clk_i);
            `CHK("edge_noise_valid", 1'b0, rx_valid)
            // Low through the middle check sample: two low votes, a start
            far.spike(ds ? 5 : 9);
            expect_word(10'h0ff, 1'b0);
        end
    endtask
    task automatic t_b2b;
        int ds;
        for (ds = 0; ds < 2; ds++) begin
            cfg(ds[0], 12'h000, 4'h8);
            // Shortest stop the receiver must tolerate, then a new start
            far.send(10'h0e1, 8, 1'b1, cpb(), ds ? 6 : 10, 1'b0);
            far.send(10'h01e, 8, 1'b1, cpb(), cpb(), 1'b0);
            expect_word(10'h0e1, 1'b0);
            expect_word(10'h01e, 1'b0);
        end
    endtask
    task automatic t_divisor;
        cfg(1'b0, 12'h003, 4'h8);
        @(posedge sys_clk_i);
        clk_en <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        clk_en <= 1'b1;
        far.send(10'h096, 8, 1'b1, cpb(), cpb(), 1'b1);
        expect_word(10'h096, 1'b0);
    endtask
    task automatic t_overrun;
        int i;
        cfg(1'b0, 12'h000, 4'h8);
        for (i = 1; i <= 3; i++) far.send(10'h010 * i[9:0], 8, 1'b1, cpb(), cpb(), 1'b0);
        repeat (20) @(negedge sys_clk_i);
        `CHK("overrun", 1'b1, ovr_seen)
        expect_word(10'h010, 1'b0);
        expect_word(10'h020, 1'b0);
        `CHK("drained", 1'b0, rx_valid)
    endtask
    task automatic test_done;
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #4000000;
        errors++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_lengths;
        t_errors;
        t_noise;
        t_b2b;
        t_divisor;
        t_overrun;
        test_done;
    end
endmodule
